// ===== hw/modulo_timer_params.svh
// Offsets, field positions, reset values and prescale limit of the modulo timer.
// Assumes inclusion by bare name from the design module.
`ifndef MODULO_TIMER_PARAMS_SVH
`define MODULO_TIMER_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define OFS_STATUS_CONTROL 2'h0
`define OFS_CLOCK_CONFIG 2'h1
`define OFS_COUNT_VALUE 2'h2
`define OFS_WRAP_LIMIT 2'h3

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define BIT_OVERFLOW 7
`define BIT_IRQ_ENABLE 6
`define BIT_COUNTER_RESET 5
`define BIT_HALT 4
`define SRC_HI 5
`define SRC_LO 4
`define PRESCALE_HI 3
`define PRESCALE_LO 0

// -----------------------------------------------------------------------------
// Reset values and limits
// -----------------------------------------------------------------------------
`define RST_COUNT 8'h00
`define RST_LIMIT 8'h00
`define RST_SOURCE 2'h0
`define RST_PRESCALE 4'h0
`define PRESCALE_MAX 4'h8

`endif

// ===== hw/modulo_timer_pkg.sv
// Types shared by the modulo timer design.
// Assumes the params header sits beside it.
package modulo_timer_pkg;
  typedef enum logic [1:0] {
    SRC_BUS = 2'b00,
    SRC_FIXED = 2'b01,
    SRC_PIN_FALL = 2'b10,
    SRC_PIN_RISE = 2'b11
  } source_t;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_STOP_SHALLOW = 2'b10,
    PWR_STOP_DEEP = 2'b11
  } power_t;
endpackage : modulo_timer_pkg

// ===== hw/modulo_timer.sv
// 8-bit modulo timer with prescaler, four clock sources and overflow request.
// Assumes a single-cycle register port, synchronous pins and one clock mclk.
`timescale 1ns/10ps
`include "modulo_timer_params.svh"

module modulo_timer
  import modulo_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic fixedRateClock,
  input wire logic extTimerClockPin,
  input wire logic [1:0] powerMode,
  input wire logic deepStopWake,
  input wire logic debugActive,
  output logic overflowIrq,
  output logic pinEdgeForPeer
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic [8:0] prescaleMask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `PRESCALE_MAX) ? `PRESCALE_MAX : sel;
    prescaleMask = (9'h001 << s) - 9'h001;
  endfunction : prescaleMask

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0] count_r, count_nxt;
  logic [7:0] limit_r, limit_nxt;
  logic overflow_r, overflow_nxt;
  logic irqEn_r, irqEn_nxt;
  logic halt_r, halt_nxt;
  logic [1:0] source_r, source_nxt;
  logic [3:0] prescale_r, prescale_nxt;
  logic [7:0] divCnt_r, divCnt_nxt;
  logic flagSeen_r, flagSeen_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic irq_r, irq_nxt;
  logic pinSync1_r, pinSync2_r, pinSync3_r, fixedPrev_r;
  logic peerEdge_r, peerEdge_nxt;
  logic srcTick, runOk, divTick, wrapHit;
  logic [8:0] mask;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Pin must run at most a quarter of mclk so every level is seen twice
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pinSync1_r <= 1'b0;
      pinSync2_r <= 1'b0;
      pinSync3_r <= 1'b0;
      fixedPrev_r <= 1'b0;
    end else begin
      pinSync1_r <= extTimerClockPin;
      pinSync2_r <= pinSync1_r;
      pinSync3_r <= pinSync2_r;
      fixedPrev_r <= fixedRateClock;
    end
  end

  // ---------------------------------------------------------------------------
  // Source select and prescaler
  // ---------------------------------------------------------------------------
  always_comb begin
    case (source_t'(source_r))
      SRC_BUS: srcTick = 1'b1;
      SRC_FIXED: srcTick = fixedRateClock & ~fixedPrev_r;
      SRC_PIN_FALL: srcTick = ~pinSync2_r & pinSync3_r;
      SRC_PIN_RISE: srcTick = pinSync2_r & ~pinSync3_r;
      default: srcTick = 1'b1;
    endcase
    // Stop modes and debug hold the counter and prescaler without losing state
    runOk = !halt_r && !debugActive && (powerMode == PWR_RUN || powerMode == PWR_WAIT);
    mask = prescaleMask(prescale_r);
    divTick = runOk && srcTick && ((divCnt_r & mask[7:0]) == mask[7:0]) ;
    wrapHit = divTick && ((limit_r == 8'h00) ? (count_r == 8'hFF) : (count_r == limit_r));
  end

  // ---------------------------------------------------------------------------
  // Registers and counter
  // ---------------------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    limit_nxt = limit_r;
    overflow_nxt = overflow_r;
    irqEn_nxt = irqEn_r;
    halt_nxt = halt_r;
    source_nxt = source_r;
    prescale_nxt = prescale_r;
    divCnt_nxt = divCnt_r;
    flagSeen_nxt = flagSeen_r;
    rdData_nxt = 8'h00;
    if (runOk && srcTick) begin
      divCnt_nxt = divCnt_r + 8'h01;
    end
    if (divTick) begin
      count_nxt = wrapHit ? 8'h00 : count_r + 8'h01;
    end
    if (regRead) begin
      if (regAddr == `OFS_STATUS_CONTROL) begin
        rdData_nxt = {overflow_r, irqEn_r, 1'b0, halt_r, 4'h0};
        flagSeen_nxt = overflow_r;
      end else if (regAddr == `OFS_CLOCK_CONFIG) begin
        rdData_nxt = {2'b00, source_r, prescale_r};
      end else if (regAddr == `OFS_COUNT_VALUE) begin
        rdData_nxt = count_r;
      end else begin
        rdData_nxt = limit_r;
      end
    end
    if (regWrite) begin
      if (regAddr == `OFS_STATUS_CONTROL) begin
        irqEn_nxt = regWrData[`BIT_IRQ_ENABLE];
        halt_nxt = regWrData[`BIT_HALT];
        if (flagSeen_r && !regWrData[`BIT_OVERFLOW]) begin
          overflow_nxt = 1'b0;
        end
        flagSeen_nxt = 1'b0;
        if (regWrData[`BIT_COUNTER_RESET]) begin
          count_nxt = `RST_COUNT;
          divCnt_nxt = 8'h00;
          overflow_nxt = 1'b0;
        end
      end else if (regAddr == `OFS_CLOCK_CONFIG) begin
        source_nxt = regWrData[`SRC_HI:`SRC_LO];
        prescale_nxt = regWrData[`PRESCALE_HI:`PRESCALE_LO];
      end else if (regAddr == `OFS_WRAP_LIMIT) begin
        limit_nxt = regWrData;
        count_nxt = `RST_COUNT;
        divCnt_nxt = 8'h00;
        overflow_nxt = 1'b0;
      end
      // Count register writes have no effect
    end
    // Hardware set wins over any clear in the same cycle
    if (wrapHit) begin
      overflow_nxt = 1'b1;
    end
  end

  // Deep-stop wake returns to reset state; shallow-stop keeps state
  always_ff @(posedge mclk) begin
    if (!rst_n || deepStopWake) begin
      count_r <= `RST_COUNT;
      limit_r <= `RST_LIMIT;
      overflow_r <= 1'b0;
      irqEn_r <= 1'b0;
      halt_r <= 1'b1;
      source_r <= `RST_SOURCE;
      prescale_r <= `RST_PRESCALE;
      divCnt_r <= 8'h00;
      flagSeen_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      limit_r <= limit_nxt;
      overflow_r <= overflow_nxt;
      irqEn_r <= irqEn_nxt;
      halt_r <= halt_nxt;
      source_r <= source_nxt;
      prescale_r <= prescale_nxt;
      divCnt_r <= divCnt_nxt;
      flagSeen_r <= flagSeen_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    // No request in stop modes so the timer never wakes the core
    irq_nxt = overflow_nxt && irqEn_nxt && !(powerMode[1]);
    peerEdge_nxt = pinSync2_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdData_r <= 8'h00;
      irq_r <= 1'b0;
      peerEdge_r <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      irq_r <= irq_nxt;
      peerEdge_r <= peerEdge_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign overflowIrq = irq_r;
  assign pinEdgeForPeer = peerEdge_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence limitWrite;
    regWrite && regAddr == `OFS_WRAP_LIMIT;
  endsequence

  chk_limit_clears_count: assert property (@(posedge mclk) disable iff (!rst_n)
    limitWrite |=> count_r == 8'h00 && (!overflow_r || $past(wrapHit)))
    else $error("Limit write did not clear counter");

  chk_reset_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    regWrite && regAddr == `OFS_STATUS_CONTROL && regWrData[5] && !deepStopWake |=> count_r == 8'h00)
    else $error("Counter reset bit ignored");

  chk_halt_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    halt_r && !regWrite && !deepStopWake |=> count_r == $past(count_r))
    else $error("Counter moved while halted");

  chk_stop_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    powerMode[1] && !regWrite && !deepStopWake |=> $stable(count_r) && !overflowIrq)
    else $error("Counter moved in stop mode");

  chk_debug_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    debugActive && !regWrite && !deepStopWake |=> $stable(count_r))
    else $error("Counter moved in debug");

  chk_wrap_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    wrapHit && !deepStopWake |=> overflow_r && count_r == 8'h00)
    else $error("Wrap did not set flag");

  chk_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    overflow_r && irqEn_r && powerMode == PWR_RUN |=> overflowIrq || !overflow_r || !irqEn_r)
    else $error("Interrupt not raised");

  chk_count_read: assert property (@(posedge mclk) disable iff (!rst_n)
    regRead && regAddr == `OFS_COUNT_VALUE |=> regRdData == $past(count_r))
    else $error("Count read mismatch");

  chk_deep_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    deepStopWake |=> halt_r && count_r == 8'h00 && limit_r == 8'h00)
    else $error("Deep wake did not reset");

  // ---------------------------------------------------------------------------
  // Checks: register port
  // ---------------------------------------------------------------------------
  chk_status_layout: assert property (@(posedge mclk) disable iff (!rst_n)
    regRead && regAddr == `OFS_STATUS_CONTROL |=> regRdData[5] == 1'b0 && regRdData[3:0] == 4'h0)
    else $error("Status unused bits not zero");

  chk_config_layout: assert property (@(posedge mclk) disable iff (!rst_n)
    regRead && regAddr == `OFS_CLOCK_CONFIG |=> regRdData == {2'b00, $past(source_r), $past(prescale_r)})
    else $error("Config readback mismatch");

  chk_limit_read: assert property (@(posedge mclk) disable iff (!rst_n)
    regRead && regAddr == `OFS_WRAP_LIMIT |=> regRdData == $past(limit_r))
    else $error("Limit readback mismatch");

  chk_limit_stored: assert property (@(posedge mclk) disable iff (!rst_n)
    limitWrite && !deepStopWake |=> limit_r == $past(regWrData))
    else $error("Limit write lost");

  // Read data is a one-cycle pulse so a late sample sees zero
  chk_idle_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    !regRead |=> regRdData == 8'h00)
    else $error("Read data outside read cycle");

  chk_count_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    regWrite && regAddr == `OFS_COUNT_VALUE && !divTick && !deepStopWake |=> $stable(count_r))
    else $error("Count write took effect");

  // ---------------------------------------------------------------------------
  // Checks: counting and sources
  // ---------------------------------------------------------------------------
  chk_count_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    limit_r != 8'h00 |-> count_r <= limit_r)
    else $error("Count passed wrap limit");

  chk_step_by_one: assert property (@(posedge mclk) disable iff (!rst_n)
    divTick && !wrapHit && !regWrite && !deepStopWake |=> count_r == $past(count_r) + 8'h01)
    else $error("Count did not step by one");

  chk_no_tick_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !divTick && !regWrite && !deepStopWake |=> $stable(count_r))
    else $error("Count moved without prescaler tick");

  chk_free_run_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    limit_r == 8'h00 && count_r == 8'hFF && divTick && !regWrite && !deepStopWake
    |=> count_r == 8'h00 && overflow_r)
    else $error("Free-run wrap missed");

  chk_wait_counts: assert property (@(posedge mclk) disable iff (!rst_n)
    powerMode == PWR_WAIT && divTick && !regWrite && !deepStopWake |=> count_r != $past(count_r))
    else $error("Counter stalled in wait");

  chk_pin_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    source_r == SRC_PIN_RISE && runOk && prescale_r == 4'h0 && pinSync2_r && !pinSync3_r && !regWrite
    && !deepStopWake |=> count_r != $past(count_r))
    else $error("Pin rising edge not counted");

  chk_pin_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    source_r == SRC_PIN_FALL && runOk && prescale_r == 4'h0 && !pinSync2_r && pinSync3_r && !regWrite
    && !deepStopWake |=> count_r != $past(count_r))
    else $error("Pin falling edge not counted");

  chk_fixed_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    source_r == SRC_FIXED && runOk && prescale_r == 4'h0 && fixedRateClock && !fixedPrev_r && !regWrite
    && !deepStopWake |=> count_r != $past(count_r))
    else $error("Fixed clock edge not counted");

  chk_source_keeps_count: assert property (@(posedge mclk) disable iff (!rst_n)
    regWrite && regAddr == `OFS_CLOCK_CONFIG && !divTick && !deepStopWake |=> $stable(count_r))
    else $error("Source change disturbed count");

  chk_peer_level: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> pinEdgeForPeer == $past(pinSync2_r))
    else $error("Peer pin level wrong");

  // ---------------------------------------------------------------------------
  // Checks: interrupt, flag and modes
  // ---------------------------------------------------------------------------
  sequence statusFlagRead;
    regRead && regAddr == `OFS_STATUS_CONTROL && overflow_r;
  endsequence

  sequence busQuiet;
    !regWrite && !deepStopWake;
  endsequence

  sequence statusZeroWrite;
    regWrite && regAddr == `OFS_STATUS_CONTROL && !regWrData[`BIT_OVERFLOW] && !wrapHit;
  endsequence

  // Gap of three idle edges matches a software read then write
  chk_flag_clear_seq: assert property (@(posedge mclk) disable iff (!rst_n)
    statusFlagRead ##1 busQuiet [*3] ##1 statusZeroWrite |=> !overflow_r)
    else $error("Flag clear sequence ignored");

  chk_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n)
    !irqEn_r && !regWrite |=> !overflowIrq)
    else $error("Interrupt raised while disabled");

  chk_deep_clears_cfg: assert property (@(posedge mclk) disable iff (!rst_n)
    deepStopWake |=> source_r == 2'b00 && prescale_r == 4'h0 && !overflow_r && !irqEn_r)
    else $error("Deep wake kept configuration");

  // No disable here: this one watches the reset itself
  chk_reset_state: assert property (@(posedge mclk)
    !rst_n |=> halt_r && count_r == 8'h00 && !overflowIrq && regRdData == 8'h00)
    else $error("Reset did not restore state");

endmodule : modulo_timer

// ===== bench/modulo_timer_tb_top.sv
// Self-checking bench for the modulo timer: registers, prescaler, sources, modes.
// Assumes the register port answers one cycle after each strobe.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module modulo_timer_tb_top;
  import modulo_timer_pkg::*;
  logic mclk, rst_n, regWrite, regRead, fixedRateClock, extTimerClockPin, deepStopWake, debugActive;
  logic [1:0] regAddr, powerMode;
  logic [7:0] regWrData, regRdData, d, v;
  logic overflowIrq, pinEdgeForPeer;
  integer seed = 43, fails = 0, cmp_count = 0, n, j, p;

  modulo_timer modulo_timer_i (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .fixedRateClock(fixedRateClock),
    .extTimerClockPin(extTimerClockPin), .powerMode(powerMode), .deepStopWake(deepStopWake),
    .debugActive(debugActive), .overflowIrq(overflowIrq), .pinEdgeForPeer(pinEdgeForPeer));

  // ---------------------------------------------------------------------------
  // Clock, bus tasks, verdict
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic wr(input logic [1:0] a, input logic [7:0] x);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= x;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] x);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    x = regRdData;
    @(posedge mclk);
  endtask : rd

  // Limit write zeroes count and prescaler, so the run length is exact
  task automatic runBus(input logic [7:0] cfg, input int m);
    wr(2'h3, 8'h00);
    wr(2'h1, cfg);
    wr(2'h0, 8'h00);
    repeat (m) @(posedge mclk);
    wr(2'h0, 8'h10);
  endtask : runBus

  // Margin of half a prescale period hides the two-cycle start/stop slack
  function automatic int spanFor(input int ps);
    return 2 * (1 << ps) + (1 << (ps - 1)) - 2;
  endfunction : spanFor

  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, regWrite, regRead, fixedRateClock, extTimerClockPin, deepStopWake, debugActive} = '0;
    regAddr = 2'h0;
    regWrData = 8'h00;
    powerMode = PWR_RUN;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(2'h0, d); `CHK(d, 8'h10)
    rd(2'h1, d); `CHK(d, 8'h00)
    rd(2'h3, d); `CHK(d, 8'h00)
    repeat (4) begin
      v = $random(seed);
      wr(2'h1, v);
      rd(2'h1, d); `CHK(d, v & 8'h3F)
      wr(2'h3, v);
      rd(2'h3, d); `CHK(d, v)
    end
    for (p = 3; p <= 8; p++) begin
      runBus(p[7:0], spanFor(p));
      rd(2'h2, d); `CHK(d, 8'h02)
      wr(2'h2, $random(seed));
      rd(2'h2, d); `CHK(d, 8'h02)
    end
    wr(2'h0, 8'h30);
    rd(2'h2, d); `CHK(d, 8'h00)
    rd(2'h0, d); `CHK(d, 8'h10)
    for (j = 0; j <= 4; j++) begin
      powerMode <= (j == 4) ? PWR_RUN : power_t'(j[1:0]);
      debugActive <= (j == 4);
      runBus(8'h03, spanFor(3));
      rd(2'h2, d); `CHK(d, (j < 2) ? 8'h02 : 8'h00)
    end
    powerMode <= PWR_RUN;
    debugActive <= 1'b0;
    for (j = 1; j <= 3; j++) begin
      n = 1 + ($random(seed) & 7);
      wr(2'h3, 8'h00);
      wr(2'h1, {2'b00, j[1:0], 4'h0});
      wr(2'h0, 8'h00);
      repeat (n) begin
        repeat (8) @(posedge mclk);
        {extTimerClockPin, fixedRateClock} <= 2'b11;
        repeat (4) @(posedge mclk);
        `CHK(pinEdgeForPeer, 1'b1)
        repeat (4) @(posedge mclk);
        {extTimerClockPin, fixedRateClock} <= 2'b00;
      end
      repeat (6) @(posedge mclk);
      `CHK(pinEdgeForPeer, 1'b0)
      wr(2'h0, 8'h10);
      rd(2'h2, d); `CHK(d, n[7:0])
    end
    runBus(8'h00, 200);
    rd(2'h0, d); `CHK(d, 8'h10)
    wr(2'h0, 8'h00);
    repeat (100) @(posedge mclk);
    wr(2'h0, 8'h10);
    rd(2'h0, d); `CHK(d, 8'h90)
    wr(2'h3, 8'h03);
    wr(2'h0, 8'h40);
    repeat (20) @(posedge mclk);
    `CHK(overflowIrq, 1'b1)
    powerMode <= PWR_STOP_SHALLOW;
    repeat (3) @(posedge mclk);
    `CHK(overflowIrq, 1'b0)
    powerMode <= PWR_RUN;
    wr(2'h0, 8'h50);
    rd(2'h0, d); `CHK(d, 8'hD0)
    wr(2'h0, 8'h50);
    rd(2'h0, d); `CHK(d, 8'h50)
    wr(2'h1, 8'h35);
    deepStopWake <= 1'b1;
    @(posedge mclk);
    deepStopWake <= 1'b0;
    rd(2'h0, d); `CHK(d, 8'h10)
    rd(2'h1, d); `CHK(d, 8'h00)
    rd(2'h3, d); `CHK(d, 8'h00)
    wr(2'h0, 8'h00);
    powerMode <= PWR_STOP_SHALLOW;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    powerMode <= PWR_RUN;
    rd(2'h0, d); `CHK(d, 8'h10)
    rd(2'h2, d); `CHK(d, 8'h00)
    tally_and_finish();
  end
endmodule : modulo_timer_tb_top
